// ==== hdl/pviu_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] Same level: best default priority wins, cleared
// [R2] Smaller vector value always wins ties
// [R3] Push PC and status at stack pointer
// [R4] Mask becomes level plus one, seven stays
// [R5] Nesting counter increments on acceptance
// [R6] Handler address fetched from base plus vector
// [R7] Acceptance takes eighteen clock cycles
// [R8] Return restores PC, status, decrements nesting
// [R9] Maskable level zero or seven never accepted
// [R10] Accept when level at least the mask
// [R11] Non-maskable sources ignore the mask
// [R12] No sampling until first handler instruction
// [R13] Reset sets mask to all ones
// [R14] Vector table is top 256 bytes
// [R15] Illegal opcode shares third trap vector
// [R16] Start code equals vector divided by four
// [R17] Transfer-end sources last, no start code
// [R18] Mask instructions load operand or seven
// [R19] Only highest level request is forwarded
// [R20] Non-maskable sources count as level seven
// [R21] Pending flag holds until vector read
module pviu_top (
	input  wire logic                               sys_clk,
	input  wire logic                               reset,
	input  wire logic                               nmi_pin,
	input  wire logic [pviu_pkg::PIN_COUNT-1:0]     ext_int_pin,
	input  wire logic                               watchdog_irq,
	input  wire logic [pviu_pkg::PERIPH_COUNT-1:0]  periph_irq,
	input  wire logic [pviu_pkg::MASK_LVL_BITS-1:0] src_level,
	input  wire logic                               software_trap,
	input  wire logic [2:0]                         trap_num,
	input  wire logic                               illegal_opcode_trap,
	input  wire logic                               set_mask_level_instr,
	input  wire logic [pviu_pkg::LVL_W-1:0]         mask_operand,
	input  wire logic                               mask_all_instr,
	input  wire logic                               return_from_interrupt,
	input  wire logic                               first_instr_done,
	input  wire logic [pviu_pkg::ADDR_W-1:0]        cpu_pc,
	input  wire logic [pviu_pkg::DATA_W-1:0]        cpu_sr,
	input  wire logic                               sp_load,
	input  wire logic [pviu_pkg::ADDR_W-1:0]        sp_value,
	input  wire logic [pviu_pkg::DATA_W-1:0]        mem_rdata,
	output var  logic                               mem_rd,
	output var  logic                               mem_wr,
	output var  logic [pviu_pkg::ADDR_W-1:0]        mem_addr,
	output var  logic [pviu_pkg::DATA_W-1:0]        mem_wdata,
	output var  logic                               pc_load,
	output var  logic [pviu_pkg::ADDR_W-1:0]        pc_value,
	output var  logic                               sr_load,
	output var  logic [pviu_pkg::DATA_W-1:0]        sr_value,
	output var  logic [pviu_pkg::LVL_W-1:0]         interrupt_mask_level,
	output var  logic [pviu_pkg::NEST_W-1:0]        nesting_counter,
	output var  logic [pviu_pkg::ADDR_W-1:0]        system_stack_pointer,
	output var  logic                               ack_valid,
	output var  logic [7:0]                         ack_vector,
	output var  logic [pviu_pkg::IDX_W-1:0]         ack_dma_code
);
	import pviu_pkg::*;

	pviu_state_t       state;
	pviu_state_t       next_state;
	logic [4:0]        step;
	logic [4:0]        next_step;
	logic [NUM_SRC-1:0] pending;
	logic [NUM_SRC-1:0] next_pending;
	logic [NUM_SRC-1:0] prev_pending;
	logic [NUM_SRC-1:0] prev_clr;
	logic [PIN_COUNT:0] pin_sync;
	logic [PIN_COUNT:0] pin_prev;
	logic [ADDR_W-1:0] saved_pc;
	logic [ADDR_W-1:0] next_saved_pc;
	logic [DATA_W-1:0] saved_sr;
	logic [DATA_W-1:0] next_saved_sr;
	logic [ADDR_W-1:0] handler;
	logic [ADDR_W-1:0] next_handler;
	logic [LVL_W-1:0]  acc_level;
	logic [LVL_W-1:0]  next_acc_level;
	logic [IDX_W-1:0]  acc_index;
	logic [IDX_W-1:0]  next_acc_index;
	logic              next_mem_rd;
	logic              next_mem_wr;
	logic [ADDR_W-1:0] next_mem_addr;
	logic [DATA_W-1:0] next_mem_wdata;
	logic              next_pc_load;
	logic [ADDR_W-1:0] next_pc_value;
	logic              next_sr_load;
	logic [DATA_W-1:0] next_sr_value;
	logic [LVL_W-1:0]  next_mask;
	logic [NEST_W-1:0] next_nest;
	logic [ADDR_W-1:0] next_sp;

	pviu_arb_if arb_bus ();

	// ----------------------------------------------------------------
	// Pin inputs and request collection
	// ----------------------------------------------------------------
	pviu_sync #(
		.WIDTH (PIN_COUNT + 1)
	) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({ext_int_pin, nmi_pin}),
		.sync_out (pin_sync)
	);

	// Pins request on a rising edge of the synchronised level
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			pin_prev <= '0;
		else
			pin_prev <= pin_sync;
	end

	// Source order: traps 0-7, NMI 8, watchdog 9, pins 10-13, peripherals
	wire [PIN_COUNT:0] pin_rise  = pin_sync & ~pin_prev;
	wire [7:0]         trap_hit  = software_trap ? (8'h01 << trap_num) : 8'h00;
	wire [7:0]         undef_hit = {5'h00, illegal_opcode_trap, 2'h0}; // [R15]
	wire [NUM_SRC-1:0] set_req   = {periph_irq, pin_rise[PIN_COUNT:1], watchdog_irq,
	                                pin_rise[0], trap_hit | undef_hit};

	// ----------------------------------------------------------------
	// Priority resolution and acceptance decision
	// ----------------------------------------------------------------
	pviu_arbiter u_arb (
		.pending   (pending),
		.src_level (src_level),
		.sys_clk   (sys_clk),
		.reset     (reset),
		.bus       (arb_bus)
	);

	// Sampling only in idle; return instruction takes precedence
	wire mask_ok = arb_bus.nonmask || (arb_bus.level >= interrupt_mask_level); // [R10] [R11]
	wire take    = (state == ST_IDLE) && !return_from_interrupt
	               && arb_bus.valid && mask_ok; // [R12]
	wire [NUM_SRC-1:0] clr_req = take ? ({{(NUM_SRC-1){1'b0}}, 1'b1} << arb_bus.index)
	                                  : '0;
	wire               in_dma  = (arb_bus.index >= IDX_W'(MASK_FIRST))
	                             && (arb_bus.index <= IDX_W'(DMA_START_LST));
	wire               mask_cmd = mask_all_instr || set_mask_level_instr;
	wire [LVL_W-1:0]   mask_val = mask_all_instr ? LVL_MAX : mask_operand; // [R18]
	wire [LVL_W-1:0]   new_mask = (acc_level == LVL_MAX) ? LVL_MAX
	                                                     : acc_level + 3'h1; // [R4]
	wire [ADDR_W-1:0]  vec_addr = VEC_BASE + {16'h0000, acc_index, 2'b00}; // [R6] [R14]
	wire [DATA_W-1:0]  sr_push  = {saved_sr[DATA_W-1:SR_MASK_LSB+LVL_W],
	                               interrupt_mask_level, saved_sr[SR_MASK_LSB-1:0]};

	// Set wins over the clear of the served flag
	assign next_pending = (pending & ~clr_req) | set_req; // [R21] [R1]

	// ----------------------------------------------------------------
	// Acceptance, return and mask sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_step      = step + 5'h01;
		next_mem_rd    = 1'b0;
		next_mem_wr    = 1'b0;
		next_mem_addr  = mem_addr;
		next_mem_wdata = mem_wdata;
		next_pc_load   = 1'b0;
		next_pc_value  = pc_value;
		next_sr_load   = 1'b0;
		next_sr_value  = sr_value;
		next_mask      = interrupt_mask_level;
		next_nest      = nesting_counter;
		next_sp        = sp_load ? sp_value : system_stack_pointer;
		next_handler   = handler;
		next_saved_pc  = saved_pc;
		next_saved_sr  = saved_sr;
		next_acc_level = acc_level;
		next_acc_index = acc_index;
		case (state)
			ST_IDLE: begin
				next_step = 5'h00;
				if (return_from_interrupt) begin
					next_state = ST_RETURN;
				end else if (take) begin
					next_state     = ST_ACCEPT;
					next_step      = STEP_PUSH_PCH;
					next_saved_pc  = cpu_pc;
					next_saved_sr  = cpu_sr;
					next_acc_level = arb_bus.level;
					next_acc_index = arb_bus.index;
				end else if (mask_cmd) begin
					next_mask = mask_val; // [R18]
				end
			end
			ST_ACCEPT: begin
				case (step)
					STEP_PUSH_PCH: begin
						next_mem_wr    = 1'b1; // [R3]
						next_mem_addr  = system_stack_pointer - WORD_STEP;
						next_mem_wdata = {8'h00, saved_pc[ADDR_W-1:DATA_W]};
					end
					STEP_PUSH_PCL: begin
						next_mem_wr    = 1'b1; // [R3]
						next_mem_addr  = system_stack_pointer - WORD_STEP - WORD_STEP;
						next_mem_wdata = saved_pc[DATA_W-1:0];
					end
					STEP_PUSH_SR: begin
						next_mem_wr    = 1'b1; // [R3]
						next_mem_addr  = system_stack_pointer - FRAME_SIZE;
						next_mem_wdata = sr_push;
						next_sp        = system_stack_pointer - FRAME_SIZE;
					end
					STEP_MASK: begin
						next_mask = new_mask; // [R4]
						next_nest = nesting_counter + 8'h01; // [R5]
					end
					STEP_TBL_LO: begin
						next_mem_rd   = 1'b1; // [R6]
						next_mem_addr = vec_addr;
					end
					STEP_TBL_HI: begin
						next_handler[DATA_W-1:0] = mem_rdata;
						next_mem_rd   = 1'b1;
						next_mem_addr = vec_addr + WORD_STEP;
					end
					STEP_TBL_END: begin
						next_handler[ADDR_W-1:DATA_W] = mem_rdata[7:0];
					end
					STEP_JUMP: begin
						next_pc_load  = 1'b1; // [R7]
						next_pc_value = handler;
						next_state    = ST_FIRST;
					end
					default: begin
					end
				endcase
			end
			ST_FIRST: begin
				// Handler's first instruction may lower or raise the mask
				next_step = 5'h00;
				if (mask_cmd)
					next_mask = mask_val; // [R18]
				if (first_instr_done)
					next_state = ST_IDLE; // [R12]
			end
			ST_RETURN: begin
				case (step)
					RET_RD_SR: begin
						next_mem_rd   = 1'b1; // [R8]
						next_mem_addr = system_stack_pointer;
					end
					RET_RD_PCL: begin
						next_saved_sr = mem_rdata;
						next_mem_rd   = 1'b1;
						next_mem_addr = system_stack_pointer + WORD_STEP;
					end
					RET_RD_PCH: begin
						next_handler[DATA_W-1:0] = mem_rdata;
						next_mem_rd   = 1'b1;
						next_mem_addr = system_stack_pointer + WORD_STEP + WORD_STEP;
					end
					RET_DONE: begin
						next_pc_load  = 1'b1; // [R8]
						next_pc_value = {mem_rdata[7:0], handler[DATA_W-1:0]};
						next_sr_load  = 1'b1;
						next_sr_value = saved_sr;
						next_mask     = saved_sr[SR_MASK_LSB +: LVL_W];
						next_sp       = system_stack_pointer + FRAME_SIZE;
						next_nest     = (nesting_counter != NEST_RESET) ?
						                nesting_counter - 8'h01 : NEST_RESET;
						next_state    = ST_IDLE;
					end
					default: begin
					end
				endcase
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Control and sequence registers
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state                <= ST_IDLE;
			step                 <= 5'h00;
			pending              <= '0;
			interrupt_mask_level <= MASK_RESET; // [R13]
			nesting_counter      <= NEST_RESET;
			system_stack_pointer <= SP_RESET;
		end else begin
			state                <= next_state;
			step                 <= next_step;
			pending              <= next_pending;
			interrupt_mask_level <= next_mask;
			nesting_counter      <= next_nest;
			system_stack_pointer <= next_sp;
		end
	end

	// Bus, program counter and status outputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_addr  <= '0;
			mem_wdata <= '0;
			pc_load   <= 1'b0;
			pc_value  <= '0;
			sr_load   <= 1'b0;
			sr_value  <= '0;
		end else begin
			mem_rd    <= next_mem_rd;
			mem_wr    <= next_mem_wr;
			mem_addr  <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			pc_load   <= next_pc_load;
			pc_value  <= next_pc_value;
			sr_load   <= next_sr_load;
			sr_value  <= next_sr_value;
		end
	end

	// Working registers of the sequence
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			saved_pc  <= '0;
			saved_sr  <= '0;
			handler   <= '0;
			acc_level <= LVL_NONE;
			acc_index <= '0;
		end else begin
			saved_pc  <= next_saved_pc;
			saved_sr  <= next_saved_sr;
			handler   <= next_handler;
			acc_level <= next_acc_level;
			acc_index <= next_acc_index;
		end
	end

	// Vector read strobe with vector and start code of the winner
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_valid    <= 1'b0;
			ack_vector   <= 8'h00;
			ack_dma_code <= NO_DMA_CODE;
		end else begin
			ack_valid    <= take;
			ack_vector   <= take ? {arb_bus.index, 2'b00} : ack_vector; // [R2]
			ack_dma_code <= !take ? ack_dma_code :
			                in_dma ? arb_bus.index : NO_DMA_CODE; // [R16] [R17]
		end
	end

	// Helper history for the flag assertion
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			prev_pending <= '0;
			prev_clr     <= '0;
		end else begin
			prev_pending <= pending;
			prev_clr     <= clr_req;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_FLAG_HOLD: assert property ( // [R21]
		@(posedge sys_clk) disable iff (reset)
		((prev_pending & ~pending & ~prev_clr) == '0))
		else $error("pending flag dropped without its vector read");
	AST_PUSH_PC: assert property ( // [R3]
		@(posedge sys_clk) disable iff (reset)
		ack_valid |=> (mem_wr && mem_addr == system_stack_pointer - WORD_STEP))
		else $error("program counter not pushed below stack pointer");
	AST_MASK_UPDATE: assert property ( // [R4]
		@(posedge sys_clk) disable iff (reset)
		ack_valid |-> ##7 (interrupt_mask_level == new_mask))
		else $error("mask not set to accepted level plus one");
	AST_NEST_INC: assert property ( // [R5]
		@(posedge sys_clk) disable iff (reset)
		ack_valid |-> ##7 (nesting_counter == $past(nesting_counter, 7) + 8'h01))
		else $error("nesting counter not incremented");
	AST_VECTOR_FETCH: assert property ( // [R6]
		@(posedge sys_clk) disable iff (reset)
		ack_valid |-> ##9 (mem_rd && mem_addr == VEC_BASE + {16'h0000, ack_vector}))
		else $error("handler address read from wrong table entry");
	AST_ACCEPT_LEN: assert property ( // [R7]
		@(posedge sys_clk) disable iff (reset)
		ack_valid |-> (!pc_load [*8] ##10 pc_load))
		else $error("acceptance did not take eighteen cycles");
	AST_RETURN_NEST: assert property ( // [R8]
		@(posedge sys_clk) disable iff (reset)
		(state == ST_RETURN && step == RET_DONE && nesting_counter != NEST_RESET)
		|=> (sr_load && nesting_counter == $past(nesting_counter) - 8'h01))
		else $error("return did not restore and decrement");
	AST_HOLD_OFF: assert property ( // [R12]
		@(posedge sys_clk) disable iff (reset)
		(state == ST_ACCEPT || state == ST_FIRST) |-> !take)
		else $error("request sampled before first handler instruction");
endmodule
`default_nettype wire

// ==== pkg/pviu_pkg.sv ====
package pviu_pkg;
	// ----------------------------------------------------------------
	// Sources and widths
	// ----------------------------------------------------------------
	localparam int NUM_SRC       = 38;
	localparam int IDX_W         = 6;
	localparam int LVL_W         = 3;
	localparam int MASK_FIRST    = 10;
	localparam int DMA_START_LST = 33;
	localparam int PIN_COUNT     = 4;
	localparam int PERIPH_COUNT  = 24;
	localparam int MASK_LVL_BITS = (NUM_SRC - MASK_FIRST) * LVL_W;
	localparam int ADDR_W        = 24;
	localparam int DATA_W        = 16;
	localparam int NEST_W        = 8;
	localparam int SR_MASK_LSB   = 12;

	// ----------------------------------------------------------------
	// Fixed values and reset values
	// ----------------------------------------------------------------
	localparam logic [LVL_W-1:0]  LVL_MAX     = 3'h7;
	localparam logic [LVL_W-1:0]  LVL_NONE    = 3'h0;
	localparam logic [LVL_W-1:0]  MASK_RESET  = 3'h7;
	localparam logic [NEST_W-1:0] NEST_RESET  = 8'h00;
	localparam logic [ADDR_W-1:0] SP_RESET    = 24'h000000;
	localparam logic [ADDR_W-1:0] VEC_BASE    = 24'hFFFF00;
	localparam logic [ADDR_W-1:0] WORD_STEP   = 24'h000002;
	localparam logic [ADDR_W-1:0] FRAME_SIZE  = 24'h000006;
	localparam logic [IDX_W-1:0]  NO_DMA_CODE = 6'h00;

	// ----------------------------------------------------------------
	// Acceptance and return sequence steps, in clock cycles
	// ----------------------------------------------------------------
	localparam int             ACCEPT_STATES = 18;
	localparam logic [4:0] STEP_PUSH_PCH = 5'h01;
	localparam logic [4:0] STEP_PUSH_PCL = 5'h03;
	localparam logic [4:0] STEP_PUSH_SR  = 5'h05;
	localparam logic [4:0] STEP_MASK     = 5'h07;
	localparam logic [4:0] STEP_TBL_LO   = 5'h09;
	localparam logic [4:0] STEP_TBL_HI   = 5'h0B;
	localparam logic [4:0] STEP_TBL_END  = 5'h0D;
	localparam logic [4:0] STEP_JUMP     = 5'(ACCEPT_STATES - 1);
	localparam logic [4:0] RET_RD_SR     = 5'h00;
	localparam logic [4:0] RET_RD_PCL    = 5'h02;
	localparam logic [4:0] RET_RD_PCH    = 5'h04;
	localparam logic [4:0] RET_DONE      = 5'h06;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCEPT = 2'b01,
		ST_FIRST  = 2'b11,
		ST_RETURN = 2'b10
	} pviu_state_t;
endpackage

// ==== pkg/pviu_arb_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Winner of the priority resolution, handed to the sequencer
interface pviu_arb_if;
	logic                      valid;
	logic [pviu_pkg::IDX_W-1:0] index;
	logic [pviu_pkg::LVL_W-1:0] level;
	logic                      nonmask;
	modport arb (output valid, output index, output level, output nonmask);
	modport seq (input valid, input index, input level, input nonmask);
endinterface
`default_nettype wire

// ==== hdl/pviu_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pviu_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// ----------------------------------------------------------------
	// Two flip-flop synchroniser per bit
	// ----------------------------------------------------------------
	genvar g;
	for (g = 0; g < WIDTH; g++) begin : g_bit
		always_ff @(posedge sys_clk or posedge reset) begin
			if (reset) begin
				meta[g]     <= 1'b0;
				sync_out[g] <= 1'b0;
			end else begin
				meta[g]     <= async_in[g];
				sync_out[g] <= meta[g];
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/pviu_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pviu_arbiter (
	input  wire logic [pviu_pkg::NUM_SRC-1:0]       pending,
	input  wire logic [pviu_pkg::MASK_LVL_BITS-1:0] src_level,
	input  wire logic                               sys_clk,
	input  wire logic                               reset,
	pviu_arb_if.arb                                 bus
);
	import pviu_pkg::*;

	logic [LVL_W-1:0] eff [NUM_SRC];
	logic [LVL_W-1:0] best_lvl;
	logic [IDX_W-1:0] best_idx;
	logic             better_seen;

	// ----------------------------------------------------------------
	// Effective level per source, zero meaning not eligible
	// ----------------------------------------------------------------
	genvar g;
	for (g = 0; g < NUM_SRC; g++) begin : g_lvl
		if (g < MASK_FIRST) begin : g_nmi
			assign eff[g] = pending[g] ? LVL_MAX : LVL_NONE; // [R20] [R11]
		end else begin : g_msk
			wire [LVL_W-1:0] lvl = src_level[(g - MASK_FIRST) * LVL_W +: LVL_W];
			wire             ok  = (lvl != LVL_NONE) && (lvl != LVL_MAX); // [R9]
			assign eff[g] = (pending[g] && ok) ? lvl : LVL_NONE;
		end
	end

	// Highest level wins, ties go to the lowest index
	always_comb begin
		best_lvl = LVL_NONE;
		best_idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (eff[i] != LVL_NONE && eff[i] >= best_lvl) begin // [R19] [R1] [R2]
				best_lvl = eff[i];
				best_idx = IDX_W'(i);
			end
		end
	end

	// Outputs towards the sequencer
	assign bus.valid   = (best_lvl != LVL_NONE);
	assign bus.index   = best_idx;
	assign bus.level   = best_lvl;
	assign bus.nonmask = (best_idx < IDX_W'(MASK_FIRST));

	// Helper: some eligible source beats the chosen one
	always_comb begin
		better_seen = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (eff[i] > best_lvl || (eff[i] == best_lvl && eff[i] != LVL_NONE
			    && IDX_W'(i) < best_idx))
				better_seen = 1'b1;
		end
	end

	AST_WINNER_BEST: assert property ( // [R1]
		@(posedge sys_clk) disable iff (reset) bus.valid |-> !better_seen)
		else $error("arbiter picked a source that is not the best");
	AST_NO_LEVEL07: assert property ( // [R9]
		@(posedge sys_clk) disable iff (reset)
		(bus.valid && !bus.nonmask) |-> (bus.level != LVL_MAX && bus.level != LVL_NONE))
		else $error("maskable source forwarded at level 0 or 7");
	AST_NMI_LEVEL: assert property ( // [R20]
		@(posedge sys_clk) disable iff (reset)
		(bus.valid && bus.nonmask) |-> bus.level == LVL_MAX)
		else $error("non-maskable source not at level 7");
endmodule
`default_nettype wire

// ==== verif/pviu_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Zero-wait memory: stack words read back as written, table words from address
module pviu_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [23:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output var  logic [15:0] mem_rdata
);
	logic [15:0] store [logic [23:0]];
	initial mem_rdata = 16'h0000;
	// Data one cycle after the strobe, a changing pattern otherwise
	always @(posedge sys_clk) begin
		if (mem_wr)
			store[mem_addr] = mem_wdata;
		if (mem_rd)
			mem_rdata <= store.exists(mem_addr) ? store[mem_addr]
				: {2{mem_addr[7:0]}};
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pviu_pkg::*;
	logic        sys_clk, reset, nmi_pin, watchdog_irq, software_trap, illegal_opcode_trap;
	logic        set_mask_level_instr, mask_all_instr, return_from_interrupt, first_instr_done;
	logic        sp_load, mem_rd, mem_wr, pc_load, sr_load, ack_valid;
	logic [3:0]  ext_int_pin;
	logic [23:0] periph_irq, cpu_pc, sp_value, mem_addr, pc_value, system_stack_pointer;
	logic [83:0] src_level;
	logic [2:0]  trap_num, mask_operand, interrupt_mask_level;
	logic [15:0] cpu_sr, mem_rdata, mem_wdata, sr_value;
	logic [7:0]  nesting_counter, ack_vector;
	logic [5:0]  ack_dma_code;
	int          compares = 0;
	int          miscompares = 0;
	int          acks = 0;
	pviu_top dut_u (.*);
	pviu_mem_model mem_u (.*);
	// Clock and acceptance count
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (ack_valid === 1'b1) acks <= acks + 1;
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Wait for a take, follow the sequence, then end the first-instruction hold
	task automatic accept(input logic [7:0] v, input logic [2:0] m);
		int i;
		i = 0;
		#1;
		while (ack_valid !== 1'b1 && i < 60) begin tick(1); i++; end
		check("vector", v, ack_vector);
		check("dma code", (v >= 8'h28 && v <= 8'h84) ? v >> 2 : 0, ack_dma_code);
		i = 0;
		while (pc_load !== 1'b1 && i < 40) begin tick(1); i++; end
		check("accept cycles", 17, i);
		check("handler", {v + 8'h02, v, v}, pc_value);
		check("mask", m, interrupt_mask_level);
		check("nest", 8'h01, nesting_counter);
		check("stack", 24'h000FFA, system_stack_pointer);
		@(posedge sys_clk) first_instr_done <= 1'b1;
		@(posedge sys_clk) first_instr_done <= 1'b0;
	endtask
	// Return and compare the restored state
	task automatic ret(input logic [2:0] m);
		int i;
		@(posedge sys_clk) return_from_interrupt <= 1'b1;
		@(posedge sys_clk) return_from_interrupt <= 1'b0;
		i = 0;
		#1;
		while (pc_load !== 1'b1 && i < 20) begin tick(1); i++; end
		check("return cycles", 7, i);
		check("return pc", 24'h123456, pc_value);
		check("return sr", {1'b0, m, 12'h000}, sr_value);
		tick(1);
		check("return mask", m, interrupt_mask_level);
		check("return nest", 8'h00, nesting_counter);
		check("return stack", 24'h001000, system_stack_pointer);
	endtask
	task automatic t_levels();
		int a;
		check("reset mask", 3'h7, interrupt_mask_level);
		check("reset nest", 8'h00, nesting_counter);
		@(posedge sys_clk) set_mask_level_instr <= 1'b1;
		@(posedge sys_clk) set_mask_level_instr <= 1'b0;
		#1;
		check("mask set", 3'h1, interrupt_mask_level);
		@(posedge sys_clk) periph_irq <= 24'h10001F;
		@(posedge sys_clk) periph_irq <= 24'h000000;
		accept(8'h40, 3'h6);
		ret(3'h1);
		accept(8'h38, 3'h4);
		ret(3'h1);
		accept(8'h3C, 3'h4);
		ret(3'h1);
		accept(8'h88, 3'h3);
		ret(3'h1);
		a = acks;
		tick(40);
		check("levels zero and seven", a, acks);
		$display("test levels done");
	endtask
	task automatic t_nonmask();
		@(posedge sys_clk) mask_all_instr <= 1'b1;
		@(posedge sys_clk) mask_all_instr <= 1'b0;
		#1;
		check("mask all", 3'h7, interrupt_mask_level);
		@(posedge sys_clk) watchdog_irq <= 1'b1;
		@(posedge sys_clk) watchdog_irq <= 1'b0;
		accept(8'h24, 3'h7);
		ret(3'h7);
		@(posedge sys_clk) nmi_pin <= 1'b1;
		accept(8'h20, 3'h7);
		ret(3'h7);
		@(posedge sys_clk) nmi_pin <= 1'b0;
		@(posedge sys_clk) illegal_opcode_trap <= 1'b1;
		@(posedge sys_clk) illegal_opcode_trap <= 1'b0;
		accept(8'h08, 3'h7);
		ret(3'h7);
		@(posedge sys_clk) software_trap <= 1'b1;
		@(posedge sys_clk) software_trap <= 1'b0;
		accept(8'h08, 3'h7);
		ret(3'h7);
		$display("test nonmask done");
	endtask
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
	// Reset, stack set-up, then the scenarios
	initial begin
		{reset, sp_load} = 2'b10;
		{nmi_pin, watchdog_irq, software_trap, illegal_opcode_trap} = 4'h0;
		{set_mask_level_instr, mask_all_instr, return_from_interrupt, first_instr_done} = 4'h0;
		{ext_int_pin, periph_irq, cpu_sr} = '0;
		{trap_num, mask_operand} = {3'h2, 3'h1};
		cpu_pc = 24'h123456;
		sp_value = 24'h001000;
		src_level = '0;
		src_level[12+:3] = 3'h3;
		src_level[15+:3] = 3'h3;
		src_level[18+:3] = 3'h5;
		src_level[24+:3] = 3'h7;
		src_level[72+:3] = 3'h2;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk) sp_load <= 1'b1;
		@(posedge sys_clk) sp_load <= 1'b0;
		tick(2);
		t_levels();
		t_nonmask();
		finish_test();
	end
endmodule
`default_nettype wire
